// [pkg/fcm_pkg.sv]
`default_nettype none
package fcm_pkg;
    localparam int AW = 21;
    localparam int DW = 16;

    // bus timing, as counts of the 40 ns system clock
    localparam int T_CLK_NS    = 40;
    localparam int T_STROBE_NS = 80;
    localparam int T_ACCESS_NS = 120;
    localparam int N_STROBE    = (T_STROBE_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int N_ACCESS    = (T_ACCESS_NS + T_CLK_NS - 1) / T_CLK_NS;

    // command sequence addresses and data
    localparam logic [AW-1:0] ADDR_UNLOCK1      = 21'h000555;
    localparam logic [AW-1:0] ADDR_UNLOCK2      = 21'h0002aa;
    localparam logic [AW-1:0] ADDR_QUERY        = 21'h000055;
    localparam logic [DW-1:0] CMD_UNLOCK1       = 16'h00aa;
    localparam logic [DW-1:0] CMD_UNLOCK2       = 16'h0055;
    localparam logic [DW-1:0] CMD_AUTOSEL       = 16'h0090;
    localparam logic [DW-1:0] CMD_SEC_ENTER     = 16'h0088;
    localparam logic [DW-1:0] CMD_SEC_EXIT1     = 16'h0090;
    localparam logic [DW-1:0] CMD_SEC_EXIT2     = 16'h0000;
    localparam logic [DW-1:0] CMD_RESET         = 16'h00f0;
    localparam logic [DW-1:0] CMD_QUERY         = 16'h0098;
    localparam logic [DW-1:0] CMD_ERASE_SUSPEND = 16'h00b0;
    localparam logic [DW-1:0] CMD_ERASE_RESUME  = 16'h0030;
    localparam logic [DW-1:0] CMD_UNLOCK_BYPASS = 16'h0020;

    // status bit of a polled read that reports an exceeded time limit
    localparam int TE_BIT = 5;

    // extended query table, word addressing
    localparam logic [AW-1:0] EXT_BASE = 21'h000040;
    localparam logic [4:0]    EXT_LEN  = 5'h10;
    localparam logic [DW-1:0] EXT_TABLE [0:14] = '{
        16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0031,
        16'h0000, 16'h0002, 16'h0004, 16'h0001, 16'h0004,
        16'h0000, 16'h0000, 16'h0000, 16'h00b5, 16'h00c5};
    localparam logic [DW-1:0] BOOT_BOTTOM = 16'h0002;
    localparam logic [DW-1:0] BOOT_TOP    = 16'h0003;

    typedef enum logic [2:0] {
        OP_READ        = 3'h0,
        OP_RAW_WRITE   = 3'h1,
        OP_RESET       = 3'h2,
        OP_AUTOSEL     = 3'h3,
        OP_SEC_ENTER   = 3'h4,
        OP_SEC_EXIT    = 3'h5,
        OP_QUERY_ENTER = 3'h6,
        OP_QUERY_CHECK = 3'h7
    } fcm_op_e;

    typedef enum logic [1:0] {
        MODE_READ    = 2'h0,
        MODE_AUTOSEL = 2'h1,
        MODE_QUERY   = 2'h2,
        MODE_SECURED = 2'h3
    } fcm_mode_e;

    function automatic logic [4:0] seq_len(input fcm_op_e op);
        case (op)
            OP_AUTOSEL, OP_SEC_ENTER: seq_len = 5'h03;
            OP_SEC_EXIT:              seq_len = 5'h04;
            OP_QUERY_CHECK:           seq_len = EXT_LEN;
            default:                  seq_len = 5'h01;
        endcase
    endfunction
endpackage
`default_nettype wire

// [hdl/fcm_bus_cycle.sv]
`default_nettype none
module fcm_bus_cycle
    import fcm_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    input  wire logic          start,
    input  wire logic          is_write,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic               done,
    output logic [DW-1:0]      rdata,
    output logic [AW-1:0]      fl_addr,
    input  wire logic [DW-1:0] fl_dq_i,
    output logic [DW-1:0]      fl_dq_o,
    output logic               fl_dq_oe,
    output logic               fl_ce_n,
    output logic               fl_oe_n,
    output logic               fl_we_n
);
    typedef enum logic [1:0] {
        BC_IDLE   = 2'b00,
        BC_SETUP  = 2'b01,
        BC_STROBE = 2'b11,
        BC_HOLD   = 2'b10
    } fcm_bc_e;

    fcm_bc_e    state_q;
    logic       wr_q;
    logic [1:0] cnt_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q  <= BC_IDLE;
            wr_q     <= 1'b0;
            cnt_q    <= 2'h0;
            done     <= 1'b0;
            rdata    <= 16'h0000;
            fl_addr  <= 21'h000000;
            fl_dq_o  <= 16'h0000;
            fl_dq_oe <= 1'b0;
            fl_ce_n  <= 1'b1;
            fl_oe_n  <= 1'b1;
            fl_we_n  <= 1'b1;
        end else begin
            done <= 1'b0;
            unique case (state_q)
                BC_IDLE: begin
                    if (start) begin
                        // address settles before either strobe falls
                        fl_addr  <= addr;
                        fl_dq_o  <= wdata;
                        fl_dq_oe <= is_write;
                        wr_q     <= is_write;
                        fl_ce_n  <= 1'b0;
                        state_q  <= BC_SETUP;
                    end
                end
                BC_SETUP: begin
                    fl_we_n <= !wr_q;
                    fl_oe_n <= wr_q;
                    cnt_q   <= wr_q ? 2'(N_STROBE - 1) : 2'(N_ACCESS - 1);
                    state_q <= BC_STROBE;
                end
                BC_STROBE: begin
                    if (cnt_q == 2'h0) begin
                        // write strobe rises while ce_n is still low, so
                        // the device latches data on this edge
                        fl_we_n <= 1'b1;
                        fl_oe_n <= 1'b1;
                        if (!wr_q) begin
                            rdata <= fl_dq_i;
                        end
                        state_q <= BC_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                BC_HOLD: begin
                    fl_ce_n  <= 1'b1;
                    fl_dq_oe <= 1'b0;
                    done     <= 1'b1;
                    state_q  <= BC_IDLE;
                end
            endcase
        end
    end

    property p_we_width;
        @(posedge clk_sys) disable iff (sys_rst)
        $fell(fl_we_n) |-> !fl_we_n [*2] ##1 fl_we_n;
    endproperty
    a_we_width: assert property (p_we_width)
        else $error("write strobe width wrong");

    property p_addr_held;
        @(posedge clk_sys) disable iff (sys_rst)
        (!fl_we_n && !fl_ce_n) |-> $stable(fl_addr) && fl_dq_oe;
    endproperty
    a_addr_held: assert property (p_addr_held)
        else $error("address or data moved during write strobe");

    property p_data_at_rise;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(fl_we_n) |-> $stable(fl_dq_o) && fl_dq_oe && !fl_ce_n;
    endproperty
    a_data_at_rise: assert property (p_data_at_rise)
        else $error("data not held at write strobe rise");
endmodule
`default_nettype wire

// [hdl/fcm_host.sv]
// Contract
// - only defined write sequences start operations; reset recovers.
// - exceeded-time flag during busy forces the host to write reset.
// - identifier sequence never issued while programming or erasing.
// - identifier mode: two unlocks plus command, then free reads.
// - secured region: three-write entry, four-write exit.
`default_nettype none
module fcm_host
    import fcm_pkg::*;
#(
    parameter bit TOP_BOOT = 1'b0
) (
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    input  wire logic          cmd_valid,
    input  wire logic [2:0]    cmd_op,
    input  wire logic [AW-1:0] cmd_addr,
    input  wire logic [DW-1:0] cmd_wdata,
    output logic               cmd_ready,
    output logic               rsp_valid,
    output logic               rsp_refused,
    output logic [DW-1:0]      rsp_data,
    output logic               rsp_auto_reset,
    output logic               check_ok,
    output logic [1:0]         dev_mode,
    output logic               erase_susp,
    output logic [AW-1:0]      fl_addr,
    input  wire logic [DW-1:0] fl_dq_i,
    output logic [DW-1:0]      fl_dq_o,
    output logic               fl_dq_oe,
    output logic               fl_ce_n,
    output logic               fl_oe_n,
    output logic               fl_we_n,
    input  wire logic          fl_ready_busy_n
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_WAIT = 2'b11,
        ST_DONE = 2'b10
    } fcm_st_e;

    fcm_st_e         state_q;
    fcm_op_e         op_q;
    fcm_op_e         req_op;
    fcm_mode_e       mode_q;
    logic [4:0]      step_q;
    logic [AW-1:0]   addr_q;
    logic [DW-1:0]   wdata_q;
    logic [DW-1:0]   rdata_q;
    logic            mismatch_q;
    logic            auto_q;
    logic [2:0]      wr_cnt_q;
    logic            busy;
    logic            accept;
    logic            refuse;
    logic            cur_wr;
    logic [AW-1:0]   cur_addr;
    logic [DW-1:0]   cur_data;
    logic            bc_done;
    logic [DW-1:0]   bc_rdata;

    assign busy   = !fl_ready_busy_n;
    assign req_op = fcm_op_e'(cmd_op);
    assign accept = cmd_valid && cmd_ready;

    function automatic logic [DW-1:0] ext_word(input logic [4:0] idx);
        if (idx < 5'h0f) begin
            ext_word = EXT_TABLE[idx[3:0]];
        end else begin
            ext_word = TOP_BOOT ? BOOT_TOP : BOOT_BOTTOM;
        end
    endfunction

    always_comb begin
        // while busy only polling reads and suspend pass
        refuse = busy && req_op != OP_READ
            && !(req_op == OP_RAW_WRITE
                 && cmd_wdata == CMD_ERASE_SUSPEND);
        if ((mode_q == MODE_AUTOSEL || mode_q == MODE_QUERY)
            && req_op != OP_READ && req_op != OP_RESET
            && req_op != OP_QUERY_CHECK) begin
            refuse = 1'b1;
        end
        if (req_op == OP_QUERY_CHECK && mode_q != MODE_QUERY) begin
            refuse = 1'b1;
        end
        if (req_op == OP_SEC_EXIT && mode_q != MODE_SECURED) begin
            refuse = 1'b1;
        end
        if (mode_q == MODE_SECURED && req_op == OP_RAW_WRITE
            && cmd_wdata == CMD_UNLOCK_BYPASS) begin
            refuse = 1'b1;
        end
    end

    // bus word for the current step of the current sequence
    always_comb begin
        cur_wr   = 1'b1;
        cur_addr = ADDR_UNLOCK1;
        cur_data = CMD_UNLOCK1;
        unique case (op_q)
            OP_READ: begin
                cur_wr   = 1'b0;
                cur_addr = addr_q;
            end
            OP_RAW_WRITE: begin
                cur_addr = addr_q;
                cur_data = wdata_q;
            end
            OP_RESET: begin
                cur_addr = addr_q;
                cur_data = CMD_RESET;
            end
            OP_AUTOSEL, OP_SEC_ENTER, OP_SEC_EXIT: begin
                if (step_q == 5'h01) begin
                    cur_addr = ADDR_UNLOCK2;
                    cur_data = CMD_UNLOCK2;
                end else if (step_q == 5'h02) begin
                    cur_data = (op_q == OP_AUTOSEL) ? CMD_AUTOSEL
                             : (op_q == OP_SEC_ENTER) ? CMD_SEC_ENTER
                             : CMD_SEC_EXIT1;
                end else if (step_q == 5'h03) begin
                    cur_data = CMD_SEC_EXIT2;
                end
            end
            OP_QUERY_ENTER: begin
                cur_addr = ADDR_QUERY;
                cur_data = CMD_QUERY;
            end
            OP_QUERY_CHECK: begin
                cur_wr   = 1'b0;
                cur_addr = EXT_BASE + AW'(step_q);
            end
        endcase
    end

    fcm_bus_cycle u_bus (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .start    (state_q == ST_RUN),
        .is_write (cur_wr),
        .addr     (cur_addr),
        .wdata    (cur_data),
        .done     (bc_done),
        .rdata    (bc_rdata),
        .fl_addr  (fl_addr),
        .fl_dq_i  (fl_dq_i),
        .fl_dq_o  (fl_dq_o),
        .fl_dq_oe (fl_dq_oe),
        .fl_ce_n  (fl_ce_n),
        .fl_oe_n  (fl_oe_n),
        .fl_we_n  (fl_we_n)
    );

    // sequencer
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q    <= ST_IDLE;
            op_q       <= OP_READ;
            step_q     <= 5'h00;
            addr_q     <= 21'h000000;
            wdata_q    <= 16'h0000;
            rdata_q    <= 16'h0000;
            mismatch_q <= 1'b0;
            auto_q     <= 1'b0;
            wr_cnt_q   <= 3'h0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (accept && !refuse) begin
                        op_q       <= req_op;
                        addr_q     <= cmd_addr;
                        wdata_q    <= cmd_wdata;
                        step_q     <= 5'h00;
                        mismatch_q <= 1'b0;
                        auto_q     <= 1'b0;
                        wr_cnt_q   <= 3'h0;
                        state_q    <= ST_RUN;
                    end
                end
                ST_RUN: state_q <= ST_WAIT;
                ST_WAIT: begin
                    if (bc_done) begin
                        rdata_q <= cur_wr ? rdata_q : bc_rdata;
                        if (cur_wr) begin
                            wr_cnt_q <= wr_cnt_q + 3'h1;
                        end
                        if (op_q == OP_QUERY_CHECK
                            && bc_rdata != ext_word(step_q)) begin
                            mismatch_q <= 1'b1;
                        end
                        step_q  <= step_q + 5'h01;
                        state_q <= (step_q + 5'h01 == seq_len(op_q))
                                 ? ST_DONE : ST_RUN;
                    end
                end
                ST_DONE: begin
                    // a timed-out embedded operation clears by reset or by an erase suspend write
                    if (op_q == OP_READ && busy && rdata_q[TE_BIT]) begin
                        op_q     <= OP_RESET;
                        step_q   <= 5'h00;
                        auto_q   <= 1'b1;
                        wr_cnt_q <= 3'h0;
                        state_q  <= ST_RUN;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // host's view of the device mode; read array after power-up
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q     <= MODE_READ;
            erase_susp <= 1'b0;
        end else if (state_q == ST_DONE
                     && !(op_q == OP_READ && busy && rdata_q[TE_BIT])) begin
            unique case (op_q)
                OP_RESET: begin
                    // the secured region is left by its exit sequence, OP_AUTOSEL or OP_QUERY_ENTER, not by reset
                    if (mode_q != MODE_SECURED) begin
                        mode_q <= MODE_READ;
                    end
                end
                OP_SEC_EXIT:           mode_q <= MODE_READ;
                OP_AUTOSEL:            mode_q <= MODE_AUTOSEL;
                OP_SEC_ENTER:          mode_q <= MODE_SECURED;
                OP_QUERY_ENTER:        mode_q <= MODE_QUERY;
                default:               mode_q <= mode_q;
            endcase
            // reset leaves suspend in place: device drops back to
            // erase-suspend-read, not plain read
            if (op_q == OP_RAW_WRITE && wdata_q == CMD_ERASE_SUSPEND) begin
                erase_susp <= 1'b1;
            end else if (op_q == OP_RAW_WRITE
                         && wdata_q == CMD_ERASE_RESUME) begin
                erase_susp <= 1'b0;
            end
        end
    end
    assign dev_mode = mode_q;

    // answer side
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_ready      <= 1'b0;
            rsp_valid      <= 1'b0;
            rsp_refused    <= 1'b0;
            rsp_data       <= 16'h0000;
            rsp_auto_reset <= 1'b0;
            check_ok       <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_q == ST_IDLE && accept && refuse) begin
                rsp_valid   <= 1'b1;
                rsp_refused <= 1'b1;
                cmd_ready   <= 1'b1;
            end else if (state_q == ST_IDLE && accept) begin
                cmd_ready <= 1'b0;
            end else if (state_q == ST_DONE && !(op_q == OP_READ
                         && busy && rdata_q[TE_BIT])) begin
                rsp_valid      <= 1'b1;
                rsp_refused    <= 1'b0;
                rsp_data       <= rdata_q;
                rsp_auto_reset <= auto_q;
                check_ok       <= (op_q == OP_QUERY_CHECK) ? !mismatch_q
                                                           : check_ok;
                cmd_ready      <= 1'b1;
            end else if (state_q == ST_IDLE) begin
                cmd_ready <= 1'b1;
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_timeout_seen;
        state_q == ST_DONE && op_q == OP_READ && busy && rdata_q[TE_BIT];
    endsequence
    property p_auto_reset;
        s_timeout_seen |=> state_q == ST_RUN && op_q == OP_RESET
                           ##1 cur_data == CMD_RESET [*1];
    endproperty
    a_auto_reset: assert property (p_auto_reset)
        else $error("exceeded time not followed by reset");

    property p_busy_refuse;
        accept && req_op == OP_AUTOSEL && busy
            |=> rsp_valid && rsp_refused && state_q == ST_IDLE;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("identifier sequence issued while busy");

    sequence s_autosel_done;
        state_q == ST_DONE && op_q == OP_AUTOSEL;
    endsequence
    property p_autosel_len;
        s_autosel_done |-> wr_cnt_q == 3'h3 ##1 mode_q == MODE_AUTOSEL;
    endproperty
    a_autosel_len: assert property (p_autosel_len)
        else $error("identifier entry not three writes");

    property p_sec_exit;
        state_q == ST_DONE && op_q == OP_SEC_EXIT
            |-> wr_cnt_q == 3'h4 ##1 mode_q == MODE_READ && rsp_valid;
    endproperty
    a_sec_exit: assert property (p_sec_exit)
        else $error("secured exit not four writes");

    property p_autosel_exit;
        $changed(mode_q) && $past(mode_q) == MODE_AUTOSEL
            |-> $past(op_q) == OP_RESET;
    endproperty
    a_autosel_exit: assert property (p_autosel_exit)
        else $error("identifier mode left without reset");

    property p_bypass_block;
        accept && mode_q == MODE_SECURED && req_op == OP_RAW_WRITE
            && cmd_wdata == CMD_UNLOCK_BYPASS |=> rsp_valid && rsp_refused;
    endproperty
    a_bypass_block: assert property (p_bypass_block)
        else $error("unlock bypass sent in secured region");

    property p_query_gate;
        accept && req_op == OP_QUERY_CHECK && mode_q != MODE_QUERY
            |=> rsp_refused ##1 state_q == ST_IDLE;
    endproperty
    a_query_gate: assert property (p_query_gate)
        else $error("table check outside query mode");
endmodule
`default_nettype wire

// [tb/fcm_flash_model.sv]
`default_nettype none
module fcm_flash_model
    import fcm_pkg::*;
#(
    parameter logic [DW-1:0] MAKER_ID = 16'h00a5, // arbitrary value
    parameter logic [DW-1:0] PART_ID  = 16'h0b0e, // arbitrary value
    parameter logic [DW-1:0] LOCK_ST  = 16'h0001
) (
    input  wire logic [AW-1:0] fl_addr,
    input  wire logic [DW-1:0] fl_dq_o,
    input  wire logic          fl_ce_n,
    input  wire logic          fl_oe_n,
    input  wire logic          fl_we_n,
    input  wire logic          fl_dq_oe,
    input  wire logic          fail_te,
    output logic [DW-1:0]      fl_dq_i,
    output logic               fl_ready_busy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // kept apart from the package table so a wrong entry there shows up
    localparam logic [DW-1:0] EXT [16] = '{
        16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0031, 16'h0000,
        16'h0002, 16'h0004, 16'h0001, 16'h0004, 16'h0000, 16'h0000,
        16'h0000, 16'h00b5, 16'h00c5, 16'h0002};
    // the table also covers
    logic [AW-1:0] a_q;
    logic [DW-1:0] last_q  = 16'h0000;
    logic [DW-1:0] rdv;
    logic [1:0]    step_q  = 2'h0;
    logic          wr_q    = 1'b0;
    logic          stuck_q = 1'b0;
    fcm_mode_e     md_q    = MODE_READ;

    assign fl_ready_busy_n = ~stuck_q;
    always @(posedge fail_te) stuck_q = 1'b1;
    always @(negedge fl_we_n or negedge fl_ce_n)
        if (!fl_we_n && !fl_ce_n) begin
            a_q = fl_addr;
            // a write with the data bus undriven is lost
            wr_q = fl_dq_oe;
        end
    always @(posedge fl_we_n or posedge fl_ce_n)
        if (wr_q) begin
            wr_q = 1'b0;
            // suspend leaves the stuck erase and serves the array again
            if (stuck_q) stuck_q = fl_dq_o != CMD_RESET
                && fl_dq_o != CMD_ERASE_SUSPEND;
            else if (fl_dq_o == CMD_RESET) begin
                step_q = 2'h0;
                if (md_q != MODE_SECURED) md_q = MODE_READ;
            end else case (step_q)
                2'h0: begin
                    if (a_q == ADDR_QUERY && fl_dq_o == CMD_QUERY)
                        md_q = MODE_QUERY;
                    else if (a_q == ADDR_UNLOCK1 && fl_dq_o == CMD_UNLOCK1)
                        step_q = 2'h1;
                end
                2'h1: begin
                    step_q = 2'h0;
                    if (a_q == ADDR_UNLOCK2 && fl_dq_o == CMD_UNLOCK2)
                        step_q = 2'h2;
                end
                2'h2: begin
                    step_q = 2'h0;
                    if (fl_dq_o == CMD_SEC_ENTER) md_q = MODE_SECURED;
                    else if (fl_dq_o == CMD_AUTOSEL && md_q == MODE_SECURED)
                        step_q = 2'h3;
                    else if (fl_dq_o == CMD_AUTOSEL) md_q = MODE_AUTOSEL;
                end
                default: begin
                    step_q = 2'h0;
                    if (fl_dq_o == CMD_SEC_EXIT2) md_q = MODE_READ;
                end
            endcase
        end
    always @* begin
        rdv = fl_addr[15:0] ^ 16'h5a5a;
        if (stuck_q) rdv = 16'h0020;
        else if (md_q == MODE_SECURED) rdv = {12'hc00, fl_addr[3:0]};
        else if (md_q == MODE_QUERY && fl_addr[AW-1:4] == 17'h00004)
            rdv = EXT[fl_addr[3:0]];
        else if (md_q == MODE_AUTOSEL) case (fl_addr[7:0])
            8'h00: rdv = MAKER_ID;
            8'h01: rdv = PART_ID;
            8'h02: rdv = 16'h0000;
            8'h03: rdv = LOCK_ST;
            default: ;
        endcase
    end
    always @(posedge fl_oe_n or posedge fl_ce_n) last_q = rdv;
    // bus has no pull: a released bus must not look like held data
    assign fl_dq_i = (fl_ce_n || fl_oe_n) ? ~last_q : rdv;
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top
    import fcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [DW-1:0] MAKER = 16'h00a5; // arbitrary value
    localparam logic [DW-1:0] PART  = 16'h0b0e; // arbitrary value
    localparam logic [DW-1:0] LOCK  = 16'h0001;
    typedef struct packed {
        logic [2:0]    op;
        logic [AW-1:0] a;
        logic [DW-1:0] wd;
        logic          rf;
        logic [DW-1:0] dat;
        logic [1:0]    md;
    } fcm_row_s;
    fcm_row_s rows [22] = '{
     '{3'h0, 21'h40, 16'h0, 1'b0, 16'h5a1a, 2'h0},
     '{3'h7, 21'h0, 16'h0, 1'b1, 16'h0, 2'h0},
     '{3'h6, 21'h0, 16'h0, 1'b0, 16'h0, 2'h2},
     '{3'h0, 21'h40, 16'h0, 1'b0, 16'h0050, 2'h2},
     '{3'h0, 21'h4f, 16'h0, 1'b0, 16'h0002, 2'h2},
     '{3'h7, 21'h0, 16'h0, 1'b0, 16'h0002, 2'h2},
     '{3'h4, 21'h0, 16'h0, 1'b1, 16'h0, 2'h2},
     '{3'h2, 21'h1abcd, 16'h0, 1'b0, 16'h0, 2'h0},
     '{3'h5, 21'h0, 16'h0, 1'b1, 16'h0, 2'h0},
     '{3'h3, 21'h0, 16'h0, 1'b0, 16'h0, 2'h1},
     '{3'h0, 21'h0, 16'h0, 1'b0, MAKER, 2'h1},
     '{3'h0, 21'h1, 16'h0, 1'b0, PART, 2'h1},
     '{3'h0, 21'h3, 16'h0, 1'b0, LOCK, 2'h1},
     '{3'h0, 21'h10002, 16'h0, 1'b0, 16'h0000, 2'h1},
     '{3'h1, 21'h0, 16'h1234, 1'b1, 16'h0, 2'h1},
     '{3'h2, 21'h0, 16'h0, 1'b0, 16'h0, 2'h0},
     '{3'h4, 21'h0, 16'h0, 1'b0, 16'h0, 2'h3},
     '{3'h2, 21'h0, 16'h0, 1'b0, 16'h0, 2'h3},
     '{3'h0, 21'h5, 16'h0, 1'b0, 16'hc005, 2'h3},
     '{3'h1, 21'h0, 16'h0020, 1'b1, 16'h0, 2'h3},
     '{3'h5, 21'h0, 16'h0, 1'b0, 16'h0, 2'h0},
     '{3'h0, 21'h5, 16'h0, 1'b0, 16'h5a5f, 2'h0}};
    logic          clk_sys = 1'b0;
    logic          sys_rst = 1'b1;
    logic          cmd_valid = 1'b0;
    logic          fail_te = 1'b0;
    logic [2:0]    cmd_op = 3'h0;
    logic [AW-1:0] cmd_addr = 21'h0;
    logic [DW-1:0] cmd_wdata = 16'h0;
    logic          cmd_ready, rsp_valid, rsp_refused, rsp_auto_reset;
    logic          check_ok, erase_susp, fl_ready_busy_n;
    logic          fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
    logic [DW-1:0] rsp_data, fl_dq_i, fl_dq_o;
    logic [AW-1:0] fl_addr;
    logic [1:0]    dev_mode;
    int            num_errors = 0;
    int            samples_checked = 0;

    always #20 clk_sys = ~clk_sys;

    fcm_host #(.TOP_BOOT(1'b0)) DUT (.clk_sys, .sys_rst, .cmd_valid,
        .cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid,
        .rsp_refused, .rsp_data, .rsp_auto_reset, .check_ok, .dev_mode,
        .erase_susp, .fl_addr, .fl_dq_i, .fl_dq_o, .fl_dq_oe, .fl_ce_n,
        .fl_oe_n, .fl_we_n, .fl_ready_busy_n);
    fcm_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART), .LOCK_ST(LOCK))
        FLASH (.fl_addr, .fl_dq_o, .fl_ce_n, .fl_oe_n, .fl_we_n, .fail_te,
        .fl_dq_oe, .fl_dq_i, .fl_ready_busy_n);

    task automatic final_report;
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [2:0] op, input logic [AW-1:0] a,
                       input logic [DW-1:0] wd);
        int k;
        int n;
        @(negedge clk_sys);
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        for (k = 0; k < 400 && cmd_ready !== 1'b1; k++) @(negedge clk_sys);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        for (n = 0; n < 400 && rsp_valid !== 1'b1; n++) @(negedge clk_sys);
        if (k == 400 || n == 400) begin
            num_errors++;
            final_report();
        end
    endtask

    initial begin
        repeat (10) @(negedge clk_sys);
        chk({13'h0, cmd_ready, fl_ce_n, fl_we_n}, 16'h0003);
        sys_rst = 1'b0;
        chk({14'h0, dev_mode}, 16'h0000);
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].a, rows[i].wd);
            chk({15'h0, rsp_refused}, {15'h0, rows[i].rf});
            chk({14'h0, dev_mode}, {14'h0, rows[i].md});
            if (rows[i].op == 3'h0) chk(rsp_data, rows[i].dat);
            if (rows[i].op == 3'h7 && !rows[i].rf) begin
                chk(rsp_data, rows[i].dat);
                chk({15'h0, check_ok}, 16'h0001);
            end
        end
        fail_te = 1'b1;
        repeat (4) @(negedge clk_sys);
        run(3'h1, 21'h0, 16'h1234);
        chk({15'h0, rsp_refused}, 16'h0001);
        run(3'h3, 21'h0, 16'h0);
        chk({15'h0, rsp_refused}, 16'h0001);
        run(3'h0, 21'h100, 16'h0);
        chk({13'h0, rsp_auto_reset, dev_mode}, 16'h0004);
        fail_te = 1'b0;
        run(3'h0, 21'h100, 16'h0);
        chk(rsp_data, 16'h5b5a);
        fail_te = 1'b1;
        run(3'h1, 21'h0, 16'h00b0);
        chk({14'h0, rsp_refused, erase_susp}, 16'h0001);
        run(3'h0, 21'h100, 16'h0);
        chk(rsp_data, 16'h5b5a);
        run(3'h1, 21'h0, 16'h0030);
        chk({15'h0, erase_susp}, 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
